// >>> rtl/lighting_host_status_words.sv
// command and status word bank for the host link of the control unit
// Notes on behaviour
// - health bit 0: zero normal, one fault
// - heartbeat command looped into heartbeat status
// - modem comm error bit follows modem link
// - module status frozen during modem comm error
// - power-off bit set while circuit unpowered
// - power off forces segment and fault-free lamps off
// - segment command stored and read back
// - full policy: all healthy modules agree
// - percentage policy: configured share agrees
// - first module policy: any healthy module agrees
// - sensor detect forced off without power
// - sensor error bit marks broken sensor
// - sensor error held during power loss
// - lamp and module errors merged or separate
// - lamp state, faulty modules keep status
// - lamp error held during power loss
// - module error held during power loss
// - failsafe when periodic writes stop
`include "lighting_status_defs.svh"
module lighting_host_status_words #(
    parameter logic [31:0] WATCHDOG = `WATCHDOG_CYCLES
) (
    input  wire logic                                clock,
    input  wire logic                                rst_n,
    input  wire lighting_status_pkg::word_req_s      req,
    output logic      [15:0]                         readData,
    output logic                                     readValid,
    input  wire logic                                unitFault,
    input  wire logic                                modemLinkLost,
    input  wire logic                                circuitPowerOff,
    input  wire logic                                sensorDetect,
    input  wire logic                                sensorBroken,
    input  wire lighting_status_pkg::module_report_s modules,
    output logic                                     failsafe
);
    localparam int NMOD = lighting_status_pkg::NMOD;

    // synchronised field inputs
    logic       [2:0]  meta;
    logic       [2:0]  sync;
    logic       [1:0]  sensMeta;
    logic       [1:0]  sensSync;
    lighting_status_pkg::module_report_s modMeta;
    lighting_status_pkg::module_report_s modSync;

    // registers
    logic       [15:0] hbCommand;
    logic              segCommand;
    logic              segState;
    logic              sensState;
    logic              sensError;
    logic [NMOD-1:0]   lampState;
    logic [NMOD-1:0]   lampError;
    logic [NMOD-1:0]   moduleError;
    logic [1:0]        policy;
    logic [6:0]        percent;
    logic              merge;
    logic [31:0]       watchCount;
    logic              failsafeReg;
    logic       [15:0] next_hbCommand;
    logic              next_segCommand;
    logic              next_segState;
    logic              next_sensState;
    logic              next_sensError;
    logic [NMOD-1:0]   next_lampState;
    logic [NMOD-1:0]   next_lampError;
    logic [NMOD-1:0]   next_moduleError;
    logic [1:0]        next_policy;
    logic [6:0]        next_percent;
    logic              next_merge;
    logic [31:0]       next_watchCount;
    logic              next_failsafe;
    logic       [15:0] next_readData;

    // per-module agreement with the commanded state
    logic [NMOD-1:0] agree;
    logic [NMOD-1:0] healthy;
    logic [3:0]      agreeCount;
    logic [3:0]      healthyCount;
    logic            powerOff;
    logic            commLost;

    // two-flop synchronisers for pins from the field side
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            meta     <= 3'h0;
            sync     <= 3'h0;
            sensMeta <= 2'h0;
            sensSync <= 2'h0;
            modMeta  <= '0;
            modSync  <= '0;
        end else begin
            meta     <= {unitFault, modemLinkLost, circuitPowerOff};
            sync     <= meta;
            sensMeta <= {sensorDetect, sensorBroken};
            sensSync <= sensMeta;
            modMeta  <= modules;
            modSync  <= modMeta;
        end
    end

    assign commLost = sync[1];
    assign powerOff = sync[0];

    genvar g;
    generate
        for (g = 0; g < NMOD; g++) begin : gen_mod
            // module counts only when it has neither fault nor lamp fault
            assign healthy[g] = !modSync.lampFault[g] && !modSync.moduleFault[g];
            assign agree[g]   = healthy[g] && (modSync.lampOn[g] == segCommand);
        end
    endgenerate

    // population counts of agreeing and healthy modules
    always_comb begin
        agreeCount   = 4'h0;
        healthyCount = 4'h0;
        for (int i = 0; i < NMOD; i++) begin
            agreeCount   = agreeCount + {3'h0, agree[i]};
            healthyCount = healthyCount + {3'h0, healthy[i]};
        end
    end

    // next state of host-written words and watchdog
    always_comb begin
        logic wr;
        wr               = req.write;
        next_hbCommand   = hbCommand;
        next_segCommand  = segCommand;
        next_policy      = policy;
        next_percent     = percent;
        next_merge       = merge;
        next_failsafe    = failsafeReg;
        next_watchCount  = watchCount;
        if (wr) begin
            unique case (req.addr)
                `ADDR_HB_COMMAND: next_hbCommand = req.data;
                `ADDR_SEG_COMMAND: begin
                    next_segCommand = req.data[0];
                end
                `ADDR_POLICY: begin
                    next_policy  = req.data[1:0];
                    next_percent = req.data[8:2];
                    next_merge   = req.data[9];
                end
                default: ; // status words ignore writes
            endcase
        end
        // failsafe on write silence, released by a segment command
        if (wr) begin
            next_watchCount = 32'h0000_0000;
        end else if (watchCount < WATCHDOG) begin
            next_watchCount = watchCount + 32'h0000_0001;
        end
        if (!wr && watchCount >= WATCHDOG - 32'h0000_0001) begin
            next_failsafe = 1'b1;
        end else if (failsafeReg && wr && req.addr == `ADDR_SEG_COMMAND) begin
            next_failsafe = 1'b0;
        end
    end

    // next state of field status words
    always_comb begin
        logic reached;
        reached = 1'b0;
        unique case (policy)
            lighting_status_pkg::POLICY_PERCENT:
                reached = ({agreeCount, 7'h00} >= (11'(healthyCount) * 11'(percent))) &&
                          (agreeCount != 4'h0);
            lighting_status_pkg::POLICY_FIRST:
                reached = (agreeCount != 4'h0);
            default:
                reached = (agreeCount == healthyCount);
        endcase
        next_segState    = segState;
        next_sensState   = sensSync[1];
        next_sensError   = sensError;
        next_lampState   = lampState;
        next_lampError   = lampError;
        next_moduleError = moduleError;
        if (reached) begin
            next_segState = segCommand;
        end
        if (powerOff) begin
            next_segState  = 1'b0;
            next_sensState = 1'b0;
            for (int i = 0; i < NMOD; i++) begin
                // faulted modules keep their lamp status
                if (!lampError[i] && !moduleError[i]) begin
                    next_lampState[i] = 1'b0;
                end
            end
            // errors held until power returns
        end else begin
            next_sensError = sensSync[0];
            if (!commLost) begin
                next_lampState   = modSync.lampOn;
                next_lampError   = modSync.lampFault;
                next_moduleError = modSync.moduleFault;
            end
            // frozen during modem comm loss
        end
    end

    // read multiplexer
    always_comb begin
        next_readData = 16'h0000;
        unique case (req.addr)
            `ADDR_UNIT_HEALTH:  next_readData[`BIT_HEALTH_FAIL] = sync[2];
            `ADDR_HB_COMMAND:   next_readData = hbCommand;
            `ADDR_HB_STATUS:    next_readData = hbCommand;
            `ADDR_MODEM: begin
                next_readData[`BIT_MODEM_COMM_ERR]  = commLost;
                next_readData[`BIT_MODEM_POWER_OFF] = powerOff;
            end
            `ADDR_SEG_COMMAND:  next_readData[0] = segCommand;
            `ADDR_SEG_STATE:    next_readData[0] = segState;
            `ADDR_SENSOR_STATE: next_readData[0] = sensState;
            `ADDR_SENSOR_ERROR: next_readData[0] = sensError;
            `ADDR_LAMP_STATE:   next_readData[NMOD-1:0] = lampState;
            `ADDR_LAMP_ERROR:
                next_readData[NMOD-1:0] = merge ? (lampError | moduleError)
                                                : lampError;
            `ADDR_MODULE_ERROR:
                next_readData[NMOD-1:0] = merge ? {NMOD{1'b0}} : moduleError;
            `ADDR_POLICY:       next_readData[9:0] = {merge, percent, policy};
            default:            next_readData = 16'h0000;
        endcase
    end

    // register all state
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            hbCommand   <= `WORD_RESET;
            segCommand  <= 1'b0;
            segState    <= 1'b0;
            sensState   <= 1'b0;
            sensError   <= 1'b0;
            lampState   <= '0;
            lampError   <= '0;
            moduleError <= '0;
            policy      <= `POLICY_RESET;
            percent     <= `PERCENT_RESET;
            merge       <= `MERGE_RESET;
            watchCount  <= 32'h0000_0000;
            failsafeReg <= 1'b1;
            readData    <= `WORD_RESET;
            readValid   <= 1'b0;
        end else begin
            hbCommand   <= next_hbCommand;
            segCommand  <= next_segCommand;
            segState    <= next_segState;
            sensState   <= next_sensState;
            sensError   <= next_sensError;
            lampState   <= next_lampState;
            lampError   <= next_lampError;
            moduleError <= next_moduleError;
            policy      <= next_policy;
            percent     <= next_percent;
            merge       <= next_merge;
            watchCount  <= next_watchCount;
            failsafeReg <= next_failsafe;
            readData    <= req.read ? next_readData : readData;
            readValid   <= req.read;
        end
    end

    assign failsafe = failsafeReg;
endmodule

// >>> rtl/lighting_status_defs.svh
// register word addresses, field positions and reset values of the status words
`ifndef LIGHTING_STATUS_DEFS_SVH
`define LIGHTING_STATUS_DEFS_SVH
`define ADDR_UNIT_HEALTH      8'h00
`define ADDR_HB_COMMAND       8'h01
`define ADDR_HB_STATUS        8'h02
`define ADDR_MODEM            8'h03
`define ADDR_SEG_COMMAND      8'h04
`define ADDR_SEG_STATE        8'h05
`define ADDR_SENSOR_STATE     8'h06
`define ADDR_SENSOR_ERROR     8'h07
`define ADDR_LAMP_STATE       8'h08
`define ADDR_LAMP_ERROR       8'h09
`define ADDR_MODULE_ERROR     8'h0A
`define ADDR_POLICY           8'h0B
`define BIT_HEALTH_FAIL       0
`define BIT_MODEM_COMM_ERR    0
`define BIT_MODEM_POWER_OFF   1
`define WORD_RESET            16'h0000
`define POLICY_RESET          2'h0
`define PERCENT_RESET         7'h64
`define MERGE_RESET           1'b0
`define WATCHDOG_CYCLES       32'd100_000_000
`endif

// >>> rtl/lighting_status_pkg.sv
// types shared by the lighting status word logic
package lighting_status_pkg;
    localparam int NMOD = 8;
    typedef enum logic [1:0] {
        POLICY_FULL    = 2'h0,
        POLICY_PERCENT = 2'h1,
        POLICY_FIRST   = 2'h2
    } policy_e;
    typedef struct packed {
        logic [7:0]  addr;
        logic        write;
        logic        read;
        logic [15:0] data;
    } word_req_s;
    typedef struct packed {
        logic [NMOD-1:0] lampOn;
        logic [NMOD-1:0] lampFault;
        logic [NMOD-1:0] moduleFault;
    } module_report_s;
endpackage

// >>> sim/field_model.sv
// lamp modules on the series circuit, answering segment commands with staggered lag
module field_model (
    input wire logic                           clock,
    input wire logic                           rst_n,
    input wire logic                           target,
    input wire logic [7:0]                     lampFault,
    input wire logic [7:0]                     moduleFault,
    output lighting_status_pkg::module_report_s modules
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] age;
    logic       held;
    // cycles since the commanded state last changed
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            age <= 8'h00;
            held <= 1'b0;
        end else begin
            held <= target;
            age <= (held != target) ? 8'h00 : ((age == 8'hFF) ? age : age + 8'h01);
        end
    end
    // module i answers 4*(i+1) cycles after a change, lamps move only by segment
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            modules.lampOn[i] = (age >= 8'(4 * (i + 1))) ? held : ~held;
        end
        modules.lampFault = lampFault;
        modules.moduleFault = moduleFault;
    end
endmodule

// >>> sim/lighting_host_status_words_chk.sv
// assertion checker for the host status word bank
module lighting_host_status_words_chk #(
    parameter logic [31:0] WATCHDOG = 32'h0000_0050
) (
    input wire logic                                clock,
    input wire logic                                rst_n,
    input wire lighting_status_pkg::word_req_s      req,
    input wire logic [15:0]                         readData,
    input wire logic                                readValid,
    input wire logic                                unitFault,
    input wire logic                                modemLinkLost,
    input wire logic                                circuitPowerOff,
    input wire logic                                sensorDetect,
    input wire logic                                sensorBroken,
    input wire lighting_status_pkg::module_report_s modules,
    input wire logic                                failsafe
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] idle;
    logic [31:0] next_idle;
    // cycles since the last host write
    always_comb next_idle = req.write ? 32'h0000_0000 : idle + 32'h0000_0001;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) idle <= 32'h0000_0000;
        else idle <= next_idle;
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    a_read_answer: assert property (req.read |=> readValid)
        else $error("read not answered");
    a_no_stray: assert property (!req.read |=> !readValid)
        else $error("stray read valid");
    a_data_holds: assert property (!readValid |-> $stable(readData))
        else $error("read data moved");
    a_hb_loop: assert property ((req.write && req.addr == 8'h01) ##1
        (req.read && !req.write && req.addr == 8'h02) |=> readData == $past(req.data, 2))
        else $error("heartbeat loopback wrong");
    a_health_bit: assert property ($stable(unitFault)[*5] ##0
        (req.read && req.addr == 8'h00) |=> readData[0] == $past(unitFault))
        else $error("health bit wrong");
    a_modem_bits: assert property (($stable(modemLinkLost) && $stable(circuitPowerOff))[*5]
        ##0 (req.read && req.addr == 8'h03)
        |=> readData[1:0] == {$past(circuitPowerOff), $past(modemLinkLost)})
        else $error("modem bits wrong");
    a_power_forced: assert property (circuitPowerOff[*5] ##0
        (req.read && (req.addr == 8'h05 || req.addr == 8'h06)) |=> readData == 16'h0000)
        else $error("state not forced off");
    a_unmapped_zero: assert property (req.read && req.addr > 8'h0B
        |=> readData == 16'h0000) else $error("unmapped read not zero");
    a_idle_safe: assert property (idle > WATCHDOG + 32'h0000_0003 |-> failsafe)
        else $error("failsafe missing");
    a_safe_clear: assert property (failsafe && req.write && req.addr == 8'h04
        |-> ##[1:2] !failsafe) else $error("failsafe not cleared");
    c_policy: cover property (req.write && req.addr == 8'h0B);
    c_power_read: cover property (circuitPowerOff && req.read && req.addr == 8'h08);
    c_safe_exit: cover property (failsafe && req.write && req.addr == 8'h04);
endmodule
bind lighting_host_status_words lighting_host_status_words_chk #(.WATCHDOG(WATCHDOG))
    i_lighting_host_status_words_chk (
    .clock(clock), .rst_n(rst_n), .req(req), .readData(readData), .readValid(readValid),
    .unitFault(unitFault), .modemLinkLost(modemLinkLost), .circuitPowerOff(circuitPowerOff),
    .sensorDetect(sensorDetect), .sensorBroken(sensorBroken), .modules(modules),
    .failsafe(failsafe));

// >>> sim/tb_lighting_host_status_words.sv
// self-checking bench for the host status word bank
`include "lighting_status_defs.svh"
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_fail++; \
    $display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb_lighting_host_status_words;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock = 1'b0, rst_n = 1'b0, unitFault = 1'b0, modemLinkLost = 1'b0;
    logic circuitPowerOff = 1'b0, sensorDetect = 1'b0, sensorBroken = 1'b0, target = 1'b0;
    logic readValid, failsafe;
    logic [7:0] lampFault = 8'h00, moduleFault = 8'h00;
    logic [15:0] readData;
    logic [15:0] hb [3] = '{16'hABCD, 16'hFFFF, 16'h0000};
    logic [15:0] early [3] = '{16'h0000, 16'h0001, 16'h0001};
    logic [1:0] pol [3] = '{2'h0, 2'h1, 2'h2};
    lighting_status_pkg::word_req_s req = '0;
    lighting_status_pkg::module_report_s modules;
    int n_fail = 0, compares = 0;
    always #5 clock = ~clock;
    lighting_host_status_words #(.WATCHDOG(32'h0000_0050)) i_lighting_host_status_words (
        .clock(clock), .rst_n(rst_n), .req(req), .readData(readData), .readValid(readValid),
        .unitFault(unitFault), .modemLinkLost(modemLinkLost), .circuitPowerOff(circuitPowerOff),
        .sensorDetect(sensorDetect), .sensorBroken(sensorBroken), .modules(modules),
        .failsafe(failsafe));
    field_model i_field_model (.clock(clock), .rst_n(rst_n), .target(target),
        .lampFault(lampFault), .moduleFault(moduleFault), .modules(modules));
    // one request at a falling edge, held until the next falling edge
    task automatic put(input logic [7:0] a, input logic w, input logic [15:0] d);
        req = '{addr: a, write: w, read: ~w, data: d};
        @(negedge clock);
    endtask
    task automatic rd(input string nm, input logic [7:0] a, input logic [15:0] e);
        put(a, 1'b0, 16'h0000);
        `CHK(nm, 1'b1, readValid)
        `CHK(nm, e, readData)
    endtask
    task automatic idle(input int n);
        req = '0;
        repeat (n) @(negedge clock);
    endtask
    task automatic report_and_stop();
        if (n_fail == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (6) @(negedge clock);
        rst_n = 1'b1;
        `CHK("failsafe", 1'b1, failsafe)
        rd("health", `ADDR_UNIT_HEALTH, 16'h0000);
        rd("hb cmd", `ADDR_HB_COMMAND, `WORD_RESET);
        for (int i = 0; i < 3; i++) begin
            put(`ADDR_HB_COMMAND, 1'b1, hb[i]);
            rd("heartbeat", `ADDR_HB_STATUS, hb[i]);
        end
        put(`ADDR_HB_STATUS, 1'b1, 16'h1234);
        put(`ADDR_UNIT_HEALTH, 1'b1, 16'hFFFF);
        rd("status ro", `ADDR_HB_STATUS, 16'h0000);
        rd("health ro", `ADDR_UNIT_HEALTH, 16'h0000);
        rd("unmapped", 8'h0C, 16'h0000);
        unitFault = 1'b1;
        modemLinkLost = 1'b1;
        idle(4);
        rd("health", `ADDR_UNIT_HEALTH, 16'h0001);
        rd("modem", `ADDR_MODEM, 16'h0001);
        lampFault = 8'h04;
        idle(4);
        rd("frozen", `ADDR_LAMP_ERROR, 16'h0000);
        unitFault = 1'b0;
        modemLinkLost = 1'b0;
        idle(4);
        rd("lamp err", `ADDR_LAMP_ERROR, 16'h0004);
        // each feedback policy, read part way and after all modules answer
        for (int i = 0; i < 3; i++) begin
            target = 1'b0;
            put(`ADDR_SEG_COMMAND, 1'b1, 16'h0000);
            idle(40);
            put(`ADDR_POLICY, 1'b1, {6'h00, 1'b0, 7'h20, pol[i]});
            target = 1'b1;
            put(`ADDR_SEG_COMMAND, 1'b1, 16'h0001);
            idle(15);
            rd("seg early", `ADDR_SEG_STATE, early[i]);
            idle(30);
            rd("seg late", `ADDR_SEG_STATE, 16'h0001);
            rd("seg cmd", `ADDR_SEG_COMMAND, 16'h0001);
        end
        sensorDetect = 1'b1;
        sensorBroken = 1'b1;
        moduleFault = 8'h02;
        idle(4);
        rd("sensor", `ADDR_SENSOR_STATE, 16'h0001);
        rd("mod err", `ADDR_MODULE_ERROR, 16'h0002);
        put(`ADDR_POLICY, 1'b1, {6'h00, 1'b1, 7'h64, 2'h0});
        rd("merged", `ADDR_LAMP_ERROR, 16'h0006);
        rd("merged mod", `ADDR_MODULE_ERROR, 16'h0000);
        put(`ADDR_POLICY, 1'b1, {6'h00, 1'b0, 7'h64, 2'h0});
        circuitPowerOff = 1'b1;
        idle(4);
        rd("power", `ADDR_MODEM, 16'h0002);
        rd("seg off", `ADDR_SEG_STATE, 16'h0000);
        rd("sensor off", `ADDR_SENSOR_STATE, 16'h0000);
        rd("lamps off", `ADDR_LAMP_STATE, 16'h0006);
        sensorBroken = 1'b0;
        lampFault = 8'h00;
        moduleFault = 8'h00;
        idle(4);
        rd("sensor err", `ADDR_SENSOR_ERROR, 16'h0001);
        rd("lamp held", `ADDR_LAMP_ERROR, 16'h0004);
        rd("mod held", `ADDR_MODULE_ERROR, 16'h0002);
        idle(90);
        `CHK("failsafe", 1'b1, failsafe)
        put(`ADDR_SEG_COMMAND, 1'b1, 16'h0000);
        idle(3);
        `CHK("failsafe", 1'b0, failsafe)
        report_and_stop();
    end
    // hang guard, far beyond the length of the sequence
    initial begin
        #50us;
        n_fail++;
        report_and_stop();
    end
endmodule
